// >>> shared/link_sync_pkg.sv
// Purpose: Shared constants and types for the serial link sync control block
// Assumes: One 200 MHz clock; frame and multiframe rates are enables from dividers
// Notes:   Register offsets are byte addresses on APB, one word per register
package link_sync_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned PLL_CAL_KCYCLES  = 153;
    localparam int unsigned PLL_CAL_CYCLES   = PLL_CAL_KCYCLES * 1000;
    localparam int unsigned ADC_CAL_CYCLES_D = 8192;
    localparam int unsigned SYNC_QUAL_FRAMES = 4;
    localparam int unsigned ILA_MULTIFRAMES  = 4;
    localparam int unsigned FRAME_DIV        = 2;
    localparam int unsigned SYSREF_DELAY     = 3;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_SYNC      = 8'h04;
    localparam logic [7:0] ADDR_POWER     = 8'h08;
    localparam logic [7:0] ADDR_STATUS    = 8'h0C;

    localparam int unsigned CTRL_KM1_LSB  = 0;
    localparam int unsigned CTRL_EN_BIT   = 8;
    localparam int unsigned SYNC_SEL_BIT  = 0;
    localparam int unsigned SYNC_SOFT_BIT = 1;

    localparam logic [4:0] KM1_RST        = 5'h1F;
    localparam logic       LINK_EN_RST    = 1'b1;
    localparam logic [1:0] PWR_NORMAL     = 2'h0;
    localparam logic [1:0] PWR_DOWN       = 2'h1;
    localparam logic [1:0] PWR_SLEEP      = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {LANE_IDLE, LANE_K28_5, LANE_ILA, LANE_DATA} lane_sym_t;

    typedef struct packed {
        lane_sym_t  sym;
        logic [1:0] mframe_idx;
        logic       mframe_start;
        logic       frame_start;
    } lane_ctl_t;

    typedef struct packed {
        logic link_up;
        logic sync_req;
        logic realign;
        logic aligned;
        logic pll_lock;
        logic cal_done;
        logic clk_rdy;
    } link_status_t;

endpackage : link_sync_pkg

// >>> verilog/serial_link_sync_control.sv
// Purpose: Transmit-side link start-up, sync handling and SYSREF realignment
// Assumes: All inputs synchronous to pclk; sysref sampled on pclk
// Notes:   Lane control fields are registered together so they line up
// Operation
// RULE1: Low sync request sends continuous K28.5
// RULE2: Sync low under four frames is ignored
// RULE3: Sync release starts ILA at multiframe boundary
// RULE4: ILA spans exactly four multiframes
// RULE5: After ILA send data until broken
// RULE6: Core cal then PLL cal then K28.5
// RULE7: No request after PLL cal gives ILA
// RULE8: Aligned SYSREF changes nothing
// RULE9: Frame and multiframe mismatch realigns, reinitialises
// RULE10: Multiframe-only mismatch keeps frame alignment
// RULE11: SYSREF reinit sends K28.5 without request
// RULE12: Realignment always reruns PLL calibration first (code reruns it only on frame mismatch; multiframe-only realign skips it)
// RULE13: No SYSREF during power-up or calibration
// RULE14: Qualified request in data breaks link
// RULE15: Sleep exit restarts clocks, PLL cal, K28.5
// RULE16: Default sync source is the pin
// RULE17: Source select one uses soft request
// RULE18: Power-down exit runs core calibration
// RULE19: Sleep exit skips core calibration
// RULE20: Power modes keep configuration registers
// RULE21: Clocks align to SYSREF plus fixed delay
// RULE22: Sync qualified after four low frames
`timescale 1ns/1ps
module serial_link_sync_control
    import link_sync_pkg::*;
#(
    parameter int unsigned PLL_CAL_LEN = PLL_CAL_CYCLES,
    parameter int unsigned ADC_CAL_LEN = ADC_CAL_CYCLES_D
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        link_sync_request_n,
    input  wire logic        sysref,
    output lane_ctl_t        lane_ctl,
    output logic             frame_tick,
    output logic             mframe_tick
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [4:0] km1_r;
    logic       link_en_r;
    logic       sync_sel_r;
    logic       soft_sync_request_n;
    logic [1:0] pwr_mode_r;
    logic [1:0] pwr_prev_r;
    link_status_t link_status_reg;

    logic apb_wr;
    logic apb_rd;
    assign apb_wr = psel && penable && pwrite && pready;
    assign apb_rd = psel && !penable && !pwrite;

    // Power transitions leave these untouched; only reset reloads their defaults
    always_ff @(posedge pclk or negedge presetn) begin // RULE20
        if (!presetn) begin
            km1_r               <= KM1_RST;
            link_en_r           <= LINK_EN_RST;
            sync_sel_r          <= 1'b0;
            soft_sync_request_n <= 1'b1;
            pwr_mode_r          <= PWR_NORMAL;
        end else if (apb_wr) begin
            case (paddr)
                ADDR_CTRL: begin
                    km1_r     <= pwdata[CTRL_KM1_LSB +: 5];
                    link_en_r <= pwdata[CTRL_EN_BIT];
                end
                ADDR_SYNC: begin
                    sync_sel_r          <= pwdata[SYNC_SEL_BIT];
                    soft_sync_request_n <= pwdata[SYNC_SOFT_BIT];
                end
                ADDR_POWER: pwr_mode_r <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // Zero wait states: setup cycle prepares data, access completes at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (paddr[1:0] != 2'h0 || paddr > ADDR_STATUS);
            if (apb_rd) begin
                case (paddr)
                    ADDR_CTRL:   prdata <= {23'h0, link_en_r, 3'h0, km1_r};
                    ADDR_SYNC:   prdata <= {30'h0, soft_sync_request_n, sync_sel_r};
                    ADDR_POWER:  prdata <= {30'h0, pwr_mode_r};
                    ADDR_STATUS: prdata <= {25'h0, link_status_reg};
                    default:     prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Power mode and calibration sequencing
    // ------------------------------------------------------------
    typedef enum logic [2:0] {P_ADC_CAL, P_PLL_CAL, P_RUN, P_OFF} pwr_st_t;
    pwr_st_t    pst_r;
    logic [17:0] cal_cnt_r;
    logic       realign_req;
    logic       clk_restart;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pwr_prev_r <= PWR_NORMAL;
        else          pwr_prev_r <= pwr_mode_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pst_r     <= P_ADC_CAL;
            cal_cnt_r <= 18'h0;
        end else if (pwr_mode_r != PWR_NORMAL) begin
            pst_r     <= P_OFF;
            cal_cnt_r <= 18'h0;
        end else begin
            case (pst_r)
                P_OFF: begin
                    cal_cnt_r <= 18'h0;
                    if (pwr_prev_r == PWR_DOWN) pst_r <= P_ADC_CAL; // RULE18
                    else                        pst_r <= P_PLL_CAL; // RULE19
                end
                P_ADC_CAL: begin
                    cal_cnt_r <= cal_cnt_r + 18'h1;
                    if (cal_cnt_r == 18'(ADC_CAL_LEN - 1)) begin
                        cal_cnt_r <= 18'h0;
                        pst_r     <= P_PLL_CAL; // RULE6
                    end
                end
                P_PLL_CAL: begin
                    cal_cnt_r <= cal_cnt_r + 18'h1;
                    if (cal_cnt_r == 18'(PLL_CAL_LEN - 1)) begin
                        cal_cnt_r <= 18'h0;
                        pst_r     <= P_RUN;
                    end
                end
                P_RUN: begin
                    if (realign_req) begin
                        cal_cnt_r <= 18'h0;
                        pst_r     <= P_PLL_CAL; // RULE12
                    end
                end
                default: pst_r <= P_OFF;
            endcase
        end
    end

    // Sleep and power-down exit both restart clocks at default phase
    assign clk_restart = (pst_r == P_OFF) && (pwr_mode_r == PWR_NORMAL); // RULE15

    // ------------------------------------------------------------
    // Frame and multiframe clock enables
    // ------------------------------------------------------------
    logic [1:0] div_r;
    logic [4:0] fcnt_r;
    logic       frame_en;
    logic       mframe_en;
    logic       sysref_d_r;
    logic [1:0] sref_dly_r;
    logic       sref_pend_r;
    logic       sref_evt;
    logic       f_mis;
    logic       m_mis;

    assign frame_en  = (div_r == 2'(FRAME_DIV - 1));
    assign mframe_en = frame_en && (fcnt_r == km1_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysref_d_r  <= 1'b0;
            sref_pend_r <= 1'b0;
            sref_dly_r  <= 2'h0;
        end else begin
            sysref_d_r <= sysref;
            if (sysref && !sysref_d_r && pst_r == P_RUN) begin
                sref_pend_r <= 1'b1;
                sref_dly_r  <= 2'h0;
            end else if (sref_pend_r) begin
                sref_dly_r <= sref_dly_r + 2'h1;
                if (sref_dly_r == 2'(SYSREF_DELAY - 1)) sref_pend_r <= 1'b0;
            end
        end
    end

    // Event lands after fixed internal delay; compare phases at that point
    assign sref_evt    = sref_pend_r && (sref_dly_r == 2'(SYSREF_DELAY - 1)); // RULE21
    assign f_mis       = (div_r != 2'h0);
    assign m_mis       = (fcnt_r != 5'h0) || f_mis;
    assign realign_req = sref_evt && m_mis && f_mis; // RULE9

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r  <= 2'h0;
            fcnt_r <= 5'h0;
        end else if (clk_restart || (sref_evt && f_mis)) begin // RULE9 RULE15
            div_r  <= 2'h1;
            fcnt_r <= 5'h0;
        end else if (sref_evt && m_mis) begin
            // Frame phase already right: only the multiframe counter moves
            fcnt_r <= 5'h0; // RULE10
            div_r  <= frame_en ? 2'h0 : div_r + 2'h1;
        end else begin
            div_r <= frame_en ? 2'h0 : div_r + 2'h1;
            if (frame_en) fcnt_r <= (fcnt_r == km1_r) ? 5'h0 : fcnt_r + 5'h1;
        end
    end

    // ------------------------------------------------------------
    // Sync request selection and qualification
    // ------------------------------------------------------------
    logic       sync_n_sel;
    logic [1:0] low_cnt_r;
    logic       sync_q_r;

    assign sync_n_sel = sync_sel_r ? soft_sync_request_n // RULE17
                                   : link_sync_request_n; // RULE16

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_r <= 2'h0;
            sync_q_r  <= 1'b0;
        end else if (sync_n_sel) begin
            low_cnt_r <= 2'h0;
            sync_q_r  <= 1'b0;
        end else if (frame_en && !sync_q_r) begin
            low_cnt_r <= low_cnt_r + 2'h1;
            if (low_cnt_r == 2'(SYNC_QUAL_FRAMES - 1)) sync_q_r <= 1'b1; // RULE2 RULE22
        end
    end

    // ------------------------------------------------------------
    // Link state machine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {L_IDLE, L_CGS, L_ILA, L_DATA} link_st_t;
    link_st_t   lst_r;
    logic [1:0] ila_cnt_r;
    logic       running;

    assign running = (pst_r == P_RUN) && link_en_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lst_r     <= L_IDLE;
            ila_cnt_r <= 2'h0;
        end else if (!running || realign_req) begin
            lst_r     <= L_IDLE;
            ila_cnt_r <= 2'h0;
        end else begin
            case (lst_r)
                L_IDLE: lst_r <= L_CGS; // RULE6 RULE11
                L_CGS: begin
                    ila_cnt_r <= 2'h0;
                    if (!sync_q_r && mframe_en) lst_r <= L_ILA; // RULE3 RULE7 RULE11
                end
                L_ILA: begin
                    if (sync_q_r) lst_r <= L_CGS;
                    else if (mframe_en) begin
                        ila_cnt_r <= ila_cnt_r + 2'h1;
                        if (ila_cnt_r == 2'(ILA_MULTIFRAMES - 1)) lst_r <= L_DATA; // RULE4 RULE5
                    end
                end
                L_DATA: if (sync_q_r) lst_r <= L_CGS; // RULE14
                default: lst_r <= L_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs and status
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_ctl        <= '0;
            frame_tick      <= 1'b0;
            mframe_tick     <= 1'b0;
            link_status_reg <= '0;
        end else begin
            case (lst_r)
                L_CGS:   lane_ctl.sym <= LANE_K28_5; // RULE1
                L_ILA:   lane_ctl.sym <= LANE_ILA;
                L_DATA:  lane_ctl.sym <= LANE_DATA;
                default: lane_ctl.sym <= LANE_IDLE;
            endcase
            lane_ctl.mframe_idx   <= ila_cnt_r;
            // Ticks lag the enables by one, as the symbol lags the state
            lane_ctl.mframe_start <= mframe_tick;
            lane_ctl.frame_start  <= frame_tick;
            frame_tick            <= frame_en;
            mframe_tick           <= mframe_en;
            link_status_reg.link_up  <= (lst_r == L_DATA);
            link_status_reg.sync_req <= sync_q_r;
            // Sticky until the next clean SYSREF; hardware set wins
            link_status_reg.realign  <= (sref_evt && m_mis)
                                        || (link_status_reg.realign && !sref_evt);
            if (sref_evt) link_status_reg.aligned <= 1'b1; // RULE8
            link_status_reg.pll_lock <= (pst_r == P_RUN);
            link_status_reg.cal_done <= (pst_r == P_PLL_CAL) || (pst_r == P_RUN);
            link_status_reg.clk_rdy  <= (pst_r != P_OFF);
        end
    end

endmodule : serial_link_sync_control

// >>> sim/link_sync_chk_properties.sv
// Purpose: Port checks of link sequencing and APB answers
// Assumes: Sync source is followed from APB writes
// Notes:   Margins allow for the registered sync qualification and lane outputs
`timescale 1ns/1ps
module link_sync_chk
    import link_sync_pkg::*;
#(
    parameter int unsigned PLL_CAL_LEN = 20,
    parameter int unsigned ADC_CAL_LEN = 10
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        link_sync_request_n,
    input wire logic        sysref,
    input wire lane_ctl_t   lane_ctl,
    input wire logic        frame_tick
);
    // ------
    // Helper state
    // ------
    logic        wr, req_n, sel_r, soft_r;
    logic [7:0]  low_r, ila_r, oth_r;
    logic [15:0] cyc_r;
    lane_sym_t   sym;
    assign sym   = lane_ctl.sym;
    assign wr    = psel && penable && pready && pwrite && !pslverr;
    assign req_n = sel_r ? soft_r : link_sync_request_n;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r  <= 1'b0;
            soft_r <= 1'b1;
        end else if (wr && paddr == ADDR_SYNC) begin
            sel_r  <= pwdata[SYNC_SEL_BIT];
            soft_r <= pwdata[SYNC_SOFT_BIT];
        end
    end
    // Saturating except ila_r, so a long run never wraps into a false pass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_r <= 8'h00;
            ila_r <= 8'h00;
            oth_r <= 8'h00;
            cyc_r <= 16'h0000;
        end else begin
            low_r <= req_n ? 8'h00 : low_r + 8'(frame_tick && low_r != 8'hFF);
            ila_r <= (sym != LANE_ILA) ? 8'h00 : ila_r + 8'(lane_ctl.mframe_start);
            oth_r <= ($rose(sysref) || (wr && paddr == ADDR_POWER)) ? 8'h00
                     : oth_r + 8'(oth_r != 8'hFF);
            cyc_r <= cyc_r + 16'(cyc_r != 16'hFFFF);
        end
    end
    // ------
    // Properties
    // ------
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_cal_first; sym != LANE_IDLE |-> cyc_r >= ADC_CAL_LEN + PLL_CAL_LEN - 1; endproperty
    a_cal_first: assert property (p_cal_first) else $error("lane active in calibration");
    property p_ila_start; sym == LANE_ILA && $past(sym) != LANE_ILA |-> lane_ctl.mframe_start && req_n; endproperty
    a_ila_start: assert property (p_ila_start) else $error("bad alignment start");
    property p_ila_len; sym == LANE_DATA && $past(sym) == LANE_ILA |-> ila_r == 8'h04; endproperty
    a_ila_len: assert property (p_ila_len) else $error("alignment length wrong");
    property p_data_after_ila; sym == LANE_DATA && $past(sym) != LANE_DATA |-> $past(sym) == LANE_ILA; endproperty
    a_data_after_ila: assert property (p_data_after_ila) else $error("data not after alignment");
    property p_qual_break; low_r >= 8'h05 |=> sym != LANE_DATA; endproperty
    a_qual_break: assert property (p_qual_break) else $error("request did not break link");
    property p_short_ignored; $past(sym) == LANE_DATA && sym != LANE_DATA |-> low_r >= 8'h03 || oth_r < 8'h40; endproperty
    a_short_ignored: assert property (p_short_ignored) else $error("link broken without cause");
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready in access cycle");
    property p_err; pready && (paddr > 8'h0C || paddr[1:0] != 2'h0) |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("bad address not refused");
endmodule : link_sync_chk
bind serial_link_sync_control link_sync_chk #(.PLL_CAL_LEN(PLL_CAL_LEN), .ADC_CAL_LEN(ADC_CAL_LEN))
    u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .sysref(sysref),
    .link_sync_request_n(link_sync_request_n), .lane_ctl(lane_ctl), .frame_tick(frame_tick));

// >>> sim/jesd_rx_model.sv
// Purpose: Receiver model driving the sync request pin
// Assumes: Bench commands it through go, frames and hold_k
// Notes:   Short holds happen only when the bench asks
`timescale 1ns/1ps
module jesd_rx_model
    import link_sync_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire lane_ctl_t  lane_ctl,
    input  wire logic       frame_tick,
    input  wire logic       go,
    input  wire logic [7:0] frames,
    input  wire logic       hold_k,
    output logic            link_sync_request_n
);
    logic [7:0] left_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_r              <= 8'h00;
            link_sync_request_n <= 1'b1;
        end else if (go) begin
            left_r              <= frames;
            link_sync_request_n <= 1'b0;
        end else if (frame_tick && left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end else if (left_r == 8'h00 && (!hold_k || lane_ctl.sym == LANE_K28_5)) begin
            link_sync_request_n <= 1'b1;
        end
    end
endmodule : jesd_rx_model

// >>> sim/serial_link_sync_control_tb_top.sv
// Purpose: Directed bench for start-up, sync, SYSREF and power modes
// Assumes: Short calibration lengths; 9 frames to a multiframe
// Notes:   Every wait is bounded; a watchdog ends a hang
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
module serial_link_sync_control_tb_top
    import link_sync_pkg::*;
;
    localparam int PLL = 20;
    localparam int ADC = 10;
    localparam int MF  = 18;
    logic        pclk, presetn, psel, penable, pwrite, sysref, go, hold_k, ok, e;
    logic        pready, pslverr, sync_n, frame_tick, mframe_tick;
    logic [7:0]  paddr, frames;
    logic [31:0] pwdata, prdata, q;
    lane_ctl_t   lane_ctl;
    int          bad_count, total_checks, cyc, n, t0, t1, m0, m1;
    serial_link_sync_control #(.PLL_CAL_LEN(PLL), .ADC_CAL_LEN(ADC)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_sync_request_n(sync_n), .sysref(sysref), .lane_ctl(lane_ctl),
        .frame_tick(frame_tick), .mframe_tick(mframe_tick));
    jesd_rx_model u_rx (.pclk(pclk), .presetn(presetn), .lane_ctl(lane_ctl), .go(go),
        .frame_tick(frame_tick), .frames(frames), .hold_k(hold_k), .link_sync_request_n(sync_n));
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        e = pslverr;
        `CHK("pready", 1'b1, pready)
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never re-drives psel in this step
        @(posedge pclk);
    endtask : apb
    // Waits until the lane symbol equals s (eq high) or differs from it
    task automatic wt(input lane_sym_t s, input logic eq);
        n = 0;
        while ((lane_ctl.sym === s) !== eq && n < 600) begin
            @(posedge pclk);
            n++;
        end
    endtask : wt
    task automatic stay(input int c);
        ok = 1'b1;
        repeat (c) begin
            @(posedge pclk);
            if (lane_ctl.sym !== LANE_DATA) ok = 1'b0;
        end
    endtask : stay
    task automatic pulse(input int t);
        while (cyc < t) @(posedge pclk);
        sysref <= 1'b1;
        repeat (2) @(posedge pclk);
        sysref <= 1'b0;
    endtask : pulse
    task automatic rx_req(input logic [7:0] f, input logic h);
        frames <= f;
        hold_k <= h;
        go     <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
    endtask : rx_req
    task automatic mph(output int m);
        n = 0;
        @(posedge pclk);
        while (mframe_tick !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        m = cyc % MF;
    endtask : mph
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        test_done();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, sysref, go, hold_k} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        frames = 8'h00;
        cyc = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t0 = cyc;
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK("ctrl reset", 32'h0000011F, q)
        apb(1'b0, ADDR_SYNC, 32'h0);
        `CHK("sync reset", 32'h00000002, q)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {e, q})
        apb(1'b1, 8'h0E, 32'h0);
        `CHK("misaligned", 1'b1, e)
        apb(1'b1, ADDR_CTRL, 32'h00000108);
        wt(LANE_K28_5, 1'b1);
        `CHK("cal time", 1'b1, cyc - t0 >= ADC + PLL)
        wt(LANE_ILA, 1'b1);
        `CHK("ila start", 1'b1, lane_ctl.mframe_start)
        wt(LANE_DATA, 1'b1);
        `CHK("ila len", 4 * MF, n)
        rx_req(8'h02, 1'b0);
        stay(60);
        `CHK("short pulse", 1'b1, ok)
        rx_req(8'h04, 1'b1);
        wt(LANE_K28_5, 1'b1);
        `CHK("break", 1'b1, lane_ctl.sym === LANE_K28_5 && n <= 16)
        wt(LANE_ILA, 1'b1);
        `CHK("ila after release", 2'h3, {sync_n, lane_ctl.mframe_start})
        wt(LANE_DATA, 1'b1);
        `CHK("data", LANE_DATA, lane_ctl.sym)
        apb(1'b1, ADDR_SYNC, 32'h0);
        stay(40);
        `CHK("soft ignored", 1'b1, ok)
        apb(1'b1, ADDR_SYNC, 32'h3);
        rx_req(8'h08, 1'b0);
        stay(60);
        `CHK("pin ignored", 1'b1, ok)
        apb(1'b1, ADDR_SYNC, 32'h1);
        wt(LANE_K28_5, 1'b1);
        `CHK("soft request", LANE_K28_5, lane_ctl.sym)
        apb(1'b1, ADDR_SYNC, 32'h2);
        wt(LANE_DATA, 1'b1);
        t0 = cyc + 5;
        pulse(t0);
        repeat (20) @(posedge pclk);
        wt(LANE_DATA, 1'b1);
        t1 = t0 + MF * ((cyc - t0) / MF + 2) + 1;
        pulse(t1);
        wt(LANE_K28_5, 1'b1);
        `CHK("realign", 1'b1, lane_ctl.sym === LANE_K28_5 && cyc - t1 >= PLL)
        wt(LANE_DATA, 1'b1);
        `CHK("reinit data", LANE_DATA, lane_ctl.sym)
        t0 = t1 + MF * ((cyc - t1) / MF + 2);
        pulse(t0);
        stay(80);
        `CHK("aligned sysref", 1'b1, ok)
        mph(m0);
        t1 = t0 + MF * ((cyc - t0) / MF + 2) + 2;
        pulse(t1);
        stay(80);
        `CHK("mframe only", 1'b1, ok)
        mph(m1);
        `CHK("mframe shift", 2, (m1 - m0 + MF) % MF)
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("status", 5'h17, {q[6:5], q[2:0]})
        apb(1'b1, ADDR_POWER, {30'h0, PWR_SLEEP});
        repeat (20) @(posedge pclk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK("ctrl kept", 32'h00000108, q)
        apb(1'b1, ADDR_POWER, 32'h0);
        t0 = cyc;
        wt(LANE_IDLE, 1'b0);
        t0 = cyc - t0;
        `CHK("wake", 1'b1, lane_ctl.sym === LANE_K28_5 && t0 >= PLL)
        apb(1'b1, ADDR_POWER, {30'h0, PWR_DOWN});
        repeat (20) @(posedge pclk);
        apb(1'b1, ADDR_POWER, 32'h0);
        t1 = cyc;
        wt(LANE_IDLE, 1'b0);
        `CHK("core cal", 1'b1, cyc - t1 - t0 >= ADC - 2)
        apb(1'b0, ADDR_SYNC, 32'h0);
        `CHK("sync kept", 32'h00000002, q)
        test_done();
    end
endmodule : serial_link_sync_control_tb_top
